// ### hdl/ahs_pkg.sv
/*
  Shared constants and types for the axis homing sequencer: register
  offsets, control and status bit positions, reset values, method numbers,
  timing constants and the carrier structs.
  Assumes a single 250 MHz clock domain for every user of this package.
*/
package ahs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int RAMP_PERIOD_NS = 1000;
  localparam int RAMP_CYC = RAMP_PERIOD_NS * CLK_MHZ / 1000;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_MODE_DISP = 8'h08;
  localparam logic [7:0] OFS_METHOD = 8'h0C;
  localparam logic [7:0] OFS_VEL_FAST = 8'h10;
  localparam logic [7:0] OFS_VEL_SLOW = 8'h14;
  localparam logic [7:0] OFS_ACCEL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_HOME_POS = 8'h20;

  localparam int CTRL_START = 4;
  localparam int STS_REACHED = 10;
  localparam int STS_ATTAINED = 12;
  localparam int STS_ERR = 13;

  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_METHOD = 8'h00;
  localparam logic [31:0] RST_VEL = 32'h0000_0000;
  localparam logic [31:0] RST_ACCEL = 32'h0000_0000;

  localparam logic [7:0] M_BASE_FIRST = 8'h01;
  localparam logic [7:0] M_BASE_LAST = 8'h0E;
  localparam logic [7:0] M_EDGE_FIRST = 8'h11;
  localparam logic [7:0] M_EDGE_LAST = 8'h1E;
  localparam logic [7:0] M_EDGE_OFS = 8'h10;
  localparam logic [7:0] M_IDX_NEG = 8'h21;
  localparam logic [7:0] M_IDX_POS = 8'h22;
  localparam logic [7:0] M_HERE_A = 8'h23;
  localparam logic [7:0] M_HERE_B = 8'h25;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ahs_req_t;

  typedef struct packed {
    logic lim_pos;
    logic lim_neg;
    logic home;
    logic index;
  } ahs_sw_t;

  typedef struct packed {
    logic valid;
    logic here;
    logic idx_only;
    logic edge_ref;
    logic lim_sw;
    logic sdir_pos;
    logic fdir_pos;
    logic leave;
    logic rev;
  } ahs_meth_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FIND, ST_LEAVE, ST_FINAL} ahs_state_t;
endpackage

// ### hdl/ahs_ramp.sv
/*
  Velocity ramp: moves the commanded velocity toward the target by one
  step every DIV clocks; a halt zeroes it at the next edge.
  Assumes target and step come from the same clock domain.
*/
`timescale 1ns/1ps
module ahs_ramp #(
  parameter int W = 32,
  parameter int DIV = ahs_pkg::RAMP_CYC
) (
  input wire logic i_clk, // Control clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic signed [W-1:0] i_target, // Wanted velocity
  input wire logic [W-1:0] i_step, // Change per ramp tick
  input wire logic i_halt, // Stop at once
  output logic signed [W-1:0] o_vel // Commanded velocity
);
  import ahs_pkg::*;
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt;
  wire logic tick = cnt == CW'(DIV - 1);
  wire logic signed [W:0] diff = {i_target[W-1], i_target} - {o_vel[W-1], o_vel};
  wire logic signed [W:0] stp = {1'b0, i_step};
  wire logic signed [W:0] up = {o_vel[W-1], o_vel} + stp;
  wire logic signed [W:0] dn = {o_vel[W-1], o_vel} - stp;
  // Final partial step lands exactly on the target, so no overshoot
  wire logic signed [W-1:0] next_vel = (diff > stp) ? up[W-1:0] :
                                       (diff < -stp) ? dn[W-1:0] : i_target;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
      o_vel <= '0;
    end else begin
      cnt <= tick ? '0 : cnt + CW'(1);
      if (i_halt) begin
        o_vel <= '0;
      end else if (tick) begin
        o_vel <= next_vel;
      end
    end
  end
endmodule

// ### hdl/ahs_sequencer.sv
/*
  Axis homing sequencer: register port, method decoder, phase state
  machine, switch and index watch, home point capture and velocity ramp.
  Assumes switch and index pins are asynchronous, position and drive
  enable come from logic on the same clock.
*/
// Function
// - Method 10: negative limit flags error, halts
// - Method 10 off switch: pass, return, slow
// - Method 10 on switch: leave, return, slow
// - Method 10 positive limit: reverse, slow finish
// - Method 11 off switch: negative, then slow
// - Method 11 negative limit: out, back, slow
// - Method 12 ends negative slow on index
// - Method 13 ends positive slow on index
// - Method 14 ends negative slow on index
// - Methods 17/18 home on limit edge
// - Methods 19-30 home on switch edge
// - Methods 33/34 run to index only
// - Methods 33/34: any switch flags error
// - Methods 35/37 take position, no motion
// - Start on rising control bit four
// - Method 1: limit search, slow index finish
// - Method 3: switch search, slow index finish
`timescale 1ns/1ps
module ahs_sequencer (
  input wire logic i_clk, // 250 MHz control clock
  input wire logic i_rst_n, // Async reset, active low
  input wire ahs_pkg::ahs_req_t i_req, // Register request
  output logic [31:0] o_rdata, // Read data, cycle after read
  input wire ahs_pkg::ahs_sw_t i_sw, // Limit, home and index pins
  input wire logic i_drive_enabled, // Drive power stage enabled
  input wire logic [31:0] i_pos, // Encoder position
  output logic signed [31:0] o_vel, // Velocity command
  output logic o_busy, // Homing motion in progress
  output logic o_attained, // Home point taken
  output logic o_error, // Homing error
  output logic [31:0] o_home_pos // Captured home position
);
  import ahs_pkg::*;

  function automatic ahs_meth_t meth_decode(input logic [7:0] m);
    ahs_meth_t r;
    logic [7:0] b;
    logic [4:0] t;
    r = '0;
    b = m;
    t = 5'h00;
    if (m >= M_EDGE_FIRST && m <= M_EDGE_LAST) begin
      b = m - M_EDGE_OFS;
      r.edge_ref = 1'b1;
    end
    // Base motion table: limit-switch, search dir, final dir, leave, reverse
    case (b)
      8'h01: t = 5'h16;
      8'h02: t = 5'h1A;
      8'h03: t = 5'h0A;
      8'h04: t = 5'h0C;
      8'h05: t = 5'h06;
      8'h06: t = 5'h00;
      8'h07: t = 5'h0B;
      8'h08: t = 5'h0D;
      8'h09: t = 5'h09;
      8'h0A: t = 5'h0F;
      8'h0B: t = 5'h07;
      8'h0C: t = 5'h01;
      8'h0D: t = 5'h05;
      8'h0E: t = 5'h03;
      default: t = 5'h00;
    endcase
    {r.lim_sw, r.sdir_pos, r.fdir_pos, r.leave, r.rev} = t;
    r.valid = b >= M_BASE_FIRST && b <= M_BASE_LAST;
    if (m == M_IDX_NEG || m == M_IDX_POS) begin
      r = '0;
      r.valid = 1'b1;
      r.idx_only = 1'b1;
      r.sdir_pos = m == M_IDX_POS;
    end
    if (m == M_HERE_A || m == M_HERE_B) begin
      r = '0;
      r.valid = 1'b1;
      r.here = 1'b1;
    end
    return r;
  endfunction

  ahs_sw_t sw;
  ahs_sw_t sw_q;
  ahs_state_t st;
  ahs_state_t next_st;
  ahs_meth_t cfg;
  logic [15:0] ctrl;
  logic [7:0] mode;
  logic [7:0] mode_disp;
  logic [7:0] method;
  logic [31:0] vel_fast;
  logic [31:0] vel_slow;
  logic [31:0] accel;
  logic [31:0] home_pos;
  logic err;
  logic attained;
  logic dir;
  logic next_dir;
  logic rev_done;
  logic next_rev;
  logic armed;
  logic next_armed;

  ahs_sync #(.W(4)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_sw),
    .o_q(sw)
  );

  // Register decode
  wire logic wr_ctrl = i_req.wr && i_req.addr == OFS_CTRL;
  wire logic wr_mode = i_req.wr && i_req.addr == OFS_MODE;
  wire logic wr_method = i_req.wr && i_req.addr == OFS_METHOD;
  wire logic wr_fast = i_req.wr && i_req.addr == OFS_VEL_FAST;
  wire logic wr_slow = i_req.wr && i_req.addr == OFS_VEL_SLOW;
  wire logic wr_accel = i_req.wr && i_req.addr == OFS_ACCEL;
  wire logic start_req = wr_ctrl & i_req.wdata[CTRL_START] & ~ctrl[CTRL_START];
  wire logic stop_req = wr_ctrl & ~i_req.wdata[CTRL_START];

  // Method in force: live register while idle, latched copy while running
  wire ahs_meth_t meth_now = meth_decode(method);
  wire ahs_meth_t cur = (st == ST_IDLE) ? meth_now : cfg;
  wire logic moving = st != ST_IDLE;
  // Moving methods need a powered drive; position-only methods do not
  wire logic accept = (st == ST_IDLE) & start_req & (mode == MODE_HOMING) & meth_now.valid &
                      (meth_now.here | i_drive_enabled);

  // Switch and index watch
  wire logic s_on = cur.lim_sw ? (cur.sdir_pos ? sw.lim_pos : sw.lim_neg) : sw.home;
  wire logic lim_fwd = cur.sdir_pos ? sw.lim_pos : sw.lim_neg;
  wire logic lim_back = cur.sdir_pos ? sw.lim_neg : sw.lim_pos;
  wire logic fwd_rise = lim_fwd & ~(cur.sdir_pos ? sw_q.lim_pos : sw_q.lim_neg);
  wire logic idx_rise = sw.index & ~sw_q.index;
  wire logic appr = ~cur.fdir_pos;
  wire logic any_sw = sw.lim_pos | sw.lim_neg | sw.home;
  // Search-side limit reverses once; while backing off it is still active, so only a fresh hit counts
  wire logic err_lim = lim_back | (lim_fwd & ~cur.lim_sw &
                       (~cur.rev | st == ST_FINAL | (rev_done & fwd_rise)));
  wire logic err_evt = moving & (cur.idx_only ? any_sw : err_lim);
  wire logic rev_evt = moving & ~err_evt & ~cur.idx_only & cur.rev & ~rev_done & lim_fwd &
                       (st != ST_FINAL);
  wire logic arm_cond = cur.leave ? ~s_on : s_on;
  wire logic fin_done = (st == ST_FINAL) & ~err_evt &
                        (cur.edge_ref ? arm_cond : ((armed | arm_cond) & idx_rise));

  always_comb begin
    next_st = st;
    next_dir = dir;
    next_rev = rev_done;
    next_armed = (st == ST_FINAL) & (armed | arm_cond);
    unique case (st)
      ST_IDLE: begin
        next_rev = 1'b0;
        if (accept & ~meth_now.here) begin
          if (meth_now.idx_only) begin
            next_st = ST_FINAL;
            next_dir = meth_now.sdir_pos;
            next_armed = 1'b1;
          end else if (s_on) begin
            next_st = ST_LEAVE;
            next_dir = meth_now.leave ? meth_now.fdir_pos : appr;
          end else begin
            next_st = ST_FIND;
            next_dir = meth_now.sdir_pos;
          end
        end
      end
      ST_FIND: begin
        if (s_on) begin
          if (cur.leave && dir == appr) begin
            next_st = ST_FINAL;
            next_dir = cur.fdir_pos;
          end else begin
            next_st = ST_LEAVE;
            next_dir = cur.leave ? cur.fdir_pos : appr;
          end
        end
      end
      ST_LEAVE: begin
        if (!s_on) begin
          if (dir == appr) begin
            next_st = ST_FINAL;
            next_dir = cur.fdir_pos;
          end else begin
            next_st = ST_FIND;
            next_dir = appr;
          end
        end
      end
      ST_FINAL: begin
        if (fin_done) begin
          next_st = ST_IDLE;
        end
      end
    endcase
    if (rev_evt) begin
      next_st = ST_FIND;
      next_dir = ~cur.sdir_pos;
      next_rev = 1'b1;
    end
    if (err_evt | (moving & stop_req)) begin
      next_st = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= ST_IDLE;
      dir <= 1'b0;
      rev_done <= 1'b0;
      armed <= 1'b0;
      cfg <= '0;
      sw_q <= '0;
    end else begin
      st <= next_st;
      dir <= next_dir;
      rev_done <= next_rev;
      armed <= next_armed;
      sw_q <= sw;
      if (accept) begin
        cfg <= meth_now;
      end
    end
  end

  // Error and attained flags; error sets only while moving, attained also on a position-only start; a clear only from idle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err <= 1'b0;
      attained <= 1'b0;
      home_pos <= '0;
    end else begin
      if (err_evt) begin
        err <= 1'b1;
      end else if (accept) begin
        err <= 1'b0;
      end
      if (fin_done | (accept & meth_now.here)) begin
        attained <= 1'b1;
        home_pos <= i_pos;
      end else if (accept) begin
        attained <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= RST_CTRL;
      mode <= RST_MODE;
      mode_disp <= RST_MODE;
      method <= RST_METHOD;
      vel_fast <= RST_VEL;
      vel_slow <= RST_VEL;
      accel <= RST_ACCEL;
    end else begin
      mode_disp <= mode;
      if (wr_ctrl) ctrl <= i_req.wdata[15:0];
      if (wr_mode) mode <= i_req.wdata[7:0];
      if (wr_method) method <= i_req.wdata[7:0];
      if (wr_fast) vel_fast <= i_req.wdata;
      if (wr_slow) vel_slow <= i_req.wdata;
      if (wr_accel) accel <= i_req.wdata;
    end
  end

  // Read path
  wire logic reached = ~moving & (o_vel == '0);
  wire logic [15:0] status = (16'(err) << STS_ERR) | (16'(attained) << STS_ATTAINED) |
                             (16'(reached) << STS_REACHED);
  wire logic [31:0] next_rdata =
    (i_req.addr == OFS_CTRL) ? {16'h0000, ctrl} :
    (i_req.addr == OFS_MODE) ? {24'h00_0000, mode} :
    (i_req.addr == OFS_MODE_DISP) ? {24'h00_0000, mode_disp} :
    (i_req.addr == OFS_METHOD) ? {24'h00_0000, method} :
    (i_req.addr == OFS_VEL_FAST) ? vel_fast :
    (i_req.addr == OFS_VEL_SLOW) ? vel_slow :
    (i_req.addr == OFS_ACCEL) ? accel :
    (i_req.addr == OFS_STATUS) ? {16'h0000, status} :
    (i_req.addr == OFS_HOME_POS) ? home_pos : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_req.rd ? next_rdata : 32'h0000_0000;
    end
  end

  // Speed select; sign bit is dropped so a huge setting cannot flip direction
  wire logic [31:0] spd = (st == ST_FINAL) ? vel_slow : vel_fast;
  wire logic signed [31:0] tgt_mag = moving ? {1'b0, spd[30:0]} : 32'h0000_0000;
  wire logic signed [31:0] tgt = dir ? tgt_mag : -tgt_mag;

  ahs_ramp #(.W(32), .DIV(RAMP_CYC)) u_ramp (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_target(tgt),
    .i_step(accel),
    .i_halt(err_evt),
    .o_vel(o_vel)
  );

  assign o_busy = moving;
  assign o_attained = attained;
  assign o_error = err;
  assign o_home_pos = home_pos;
  wire logic [31:0] vel_mag = o_vel[31] ? -o_vel : o_vel;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_err_halts:
    assert property (err_evt |=> err && o_vel == '0 && st == ST_IDLE)
      else $error("error event did not halt motor");
  a_neg_lim_m10:
    assert property (moving && cfg.rev && cfg.sdir_pos && sw.lim_neg |=> err)
      else $error("negative limit did not flag error");
  a_idx_only_sw:
    assert property (moving && cfg.idx_only && sw.home |=> err ##1 o_vel == '0)
      else $error("switch during index-only run not flagged");
  a_start_edge:
    assert property (st == ST_IDLE && !start_req |=> st == ST_IDLE)
      else $error("motion began without start edge");
  a_here_capture:
    assert property (accept && meth_now.here |=> attained && st == ST_IDLE && home_pos == $past(i_pos))
      else $error("position-only method misbehaved");
  a_err_sticky:
    assert property (err && !accept |=> err)
      else $error("error cleared without new start");
  a_err_clear:
    assert property (accept |=> !err)
      else $error("error not cleared on new start");
  a_final_slow:
    assert property (st == ST_FINAL && $past(st) == ST_FINAL |->
                     vel_mag <= $past(vel_mag) || vel_mag <= {1'b0, vel_slow[30:0]})
      else $error("final phase ran faster than slow speed");
  a_final_dir:
    assert property ($rose(st == ST_FINAL) && !cfg.idx_only |-> dir == cfg.fdir_pos)
      else $error("final phase in wrong direction");
  a_done_capture:
    assert property (fin_done |=> attained && st == ST_IDLE && home_pos == $past(i_pos))
      else $error("home point not captured");

  c_done: cover property (st == ST_FINAL ##1 st == ST_IDLE && attained);
  c_error: cover property (moving ##1 err);
  c_reverse: cover property (rev_evt ##[1:1000] st == ST_FINAL);
endmodule

// ### hdl/ahs_sync.sv
/*
  Two flip-flop synchroniser, one chain per bit.
  Assumes the inputs are slow pins; pulses must be wider than two clocks.
*/
`timescale 1ns/1ps
module ahs_sync #(
  parameter int W = 4
) (
  input wire logic i_clk, // Control clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [W-1:0] i_d, // Asynchronous pins
  output logic [W-1:0] o_q // Synchronised levels
);
  import ahs_pkg::*;
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta;
    logic q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        meta <= 1'b0;
        q <= 1'b0;
      end else begin
        meta <= i_d[g];
        q <= meta;
      end
    end
    assign o_q[g] = q;
  end
endmodule

// ### tb/ahs_axis_model.sv
/*
  Axis model: integrates the velocity command into a position and derives
  the limit, home and index pins from it, like a real slide with cams.
  Assumes one velocity unit per clock; the bench presets the position
  through the load port between runs, while the axis stands still.
*/
`timescale 1ns/1ps
module ahs_axis_model (
  input wire logic i_clk, // Control clock
  input wire logic signed [31:0] i_vel, // Velocity command
  input wire logic i_load, // Preset the position at this edge
  input wire logic signed [31:0] i_load_pos, // Position to preset
  input wire ahs_pkg::ahs_sw_t i_force, // Faults forced by the bench
  output logic [31:0] o_pos, // Axis position
  output ahs_pkg::ahs_sw_t o_sw // Limit, home and index pins
);
  import ahs_pkg::*;
  localparam logic signed [31:0] NEG_LIM = -32'sh9C40;
  localparam logic signed [31:0] POS_LIM = 32'sh1D4C0;
  localparam logic signed [31:0] HOME_LO = 32'sh9C40;
  localparam logic signed [31:0] HOME_HI = 32'shEA60;
  logic signed [31:0] pos = 32'sh0;
  always @(posedge i_clk) begin
    pos <= i_load ? i_load_pos : pos + i_vel;
  end
  assign o_pos = pos;
  assign o_sw.lim_neg = (pos <= NEG_LIM) | i_force.lim_neg;
  assign o_sw.lim_pos = (pos >= POS_LIM) | i_force.lim_pos;
  assign o_sw.home = (pos >= HOME_LO && pos <= HOME_HI) | i_force.home;
  // Index is a narrow cam every 8192 units, wide enough at fast speed
  assign o_sw.index = pos[12:0] < 13'h0200;
endmodule

// ### tb/ahs_sequencer_tb.sv
/*
  Bench for the homing sequencer: register traffic, still and moving
  methods, forced switch faults. Assumes the axis model drives the pins.
*/
`timescale 1ns/1ps
module ahs_sequencer_tb;
  import ahs_pkg::*;
  localparam logic [31:0] FAST = 32'h8;
  localparam logic [31:0] SLOW = 32'h1;
  localparam logic [31:0] ACC = 32'h4;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic drv_en = 1'b0;
  logic att_d = 1'b0;
  logic ld = 1'b0;
  logic [31:0] ldv = '0;
  ahs_req_t req = '0;
  ahs_sw_t sw;
  ahs_sw_t frc = '0;
  logic [31:0] pos, o_rdata, o_home_pos, p;
  logic [31:0] lfsr = 32'hF873;
  logic signed [31:0] o_vel, prev = '0, cap = '0, peak = '0;
  logic o_busy, o_attained, o_error;
  int errors = 0;
  int n_checks = 0;
  int ramp_bad = 0;
  always #2 i_clk = ~i_clk;
  ahs_sequencer uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(o_rdata), .i_sw(sw),
    .i_drive_enabled(drv_en), .i_pos(pos), .o_vel(o_vel), .o_busy(o_busy),
    .o_attained(o_attained), .o_error(o_error), .o_home_pos(o_home_pos));
  ahs_axis_model axis (.i_clk(i_clk), .i_vel(o_vel), .i_load(ld), .i_load_pos(ldv), .i_force(frc),
    .o_pos(pos), .o_sw(sw));
  // Error stops are allowed to jump; every other change must ramp
  always @(negedge i_clk) begin
    if (o_error === 1'b0 && (o_vel - prev > $signed(ACC) || prev - o_vel > $signed(ACC))) ramp_bad++;
    if (o_vel > peak) peak = o_vel;
    if (-o_vel > peak) peak = -o_vel;
    if (o_attained === 1'b1 && att_d !== 1'b1) cap = o_vel;
    att_d = o_attained;
    prev = o_vel;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic signed [31:0] fin_dir(input logic [7:0] m);
    return (m == 8'h03 || m == 8'h0C || m == 8'h0E || m == M_IDX_NEG) ? -$signed(SLOW) : $signed(SLOW);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    req <= '0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_clk);
    req <= '0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), exp, o_rdata);
    @(posedge i_clk);
  endtask
  task automatic start(input logic [7:0] m, input logic [31:0] p0);
    ld <= 1'b1;
    ldv <= p0;
    @(posedge i_clk);
    ld <= 1'b0;
    peak = '0;
    wr(OFS_METHOD, {24'h0, m});
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h10);
  endtask
  task automatic run(input logic [7:0] m, input logic [31:0] p0);
    start(m, p0);
    for (int i = 0; i < 40000 && o_busy === 1'b1; i++) @(negedge i_clk);
    for (int i = 0; i < 2000 && o_vel !== '0; i++) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  task automatic chk_run(input logic [7:0] m);
    chk("attained", 32'h1, {31'h0, o_attained});
    chk("error", 32'h0, {31'h0, o_error});
    chk("final vel", fin_dir(m), cap);
    chk("peak vel", (m >= M_IDX_NEG) ? SLOW : FAST, peak);
    if (m < M_EDGE_FIRST || m >= M_IDX_NEG) chk("on index", 32'h1, {31'h0, o_home_pos[12:0] < 13'h0200});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge i_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(posedge i_clk);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_METHOD, 32'h0);
    rdc(8'h30, 32'h0);
    wr(OFS_MODE, 32'h6);
    rdc(OFS_MODE_DISP, 32'h6);
    wr(OFS_VEL_FAST, FAST);
    wr(OFS_VEL_SLOW, SLOW);
    wr(OFS_ACCEL, ACC);
    rdc(OFS_VEL_SLOW, SLOW);
    wr(OFS_HOME_POS, 32'hFFFF_FFFF);
    rdc(OFS_HOME_POS, 32'h0);
    // Still methods with the power stage off
    for (int k = 0; k < 2; k++) begin
      lfsr = nxt(lfsr);
      p = lfsr;
      run(k ? M_HERE_B : M_HERE_A, p);
      chk("here pos", p, o_home_pos);
      chk("here busy", 32'h0, {31'h0, o_busy});
      ld <= 1'b1;
      ldv <= ~p;
      @(posedge i_clk);
      ld <= 1'b0;
      wr(OFS_CTRL, 32'h10);
      chk("held start", p, o_home_pos);
    end
    // A moving method must not start while the power stage is off
    start(8'h0B, 32'h0001_3880);
    @(negedge i_clk);
    chk("unpowered busy", 32'h0, {31'h0, o_busy});
    @(posedge i_clk);
    drv_en <= 1'b1;
    run(8'h0B, 32'h0001_3880);
    chk_run(8'h0B);
    run(8'h0A, 32'h0001_3880);
    chk_run(8'h0A);
    run(8'h0C, 32'h0001_3880);
    chk_run(8'h0C);
    run(8'h1B, 32'h0001_3880);
    chk_run(8'h1B);
    chk("edge pos", 32'h1, {31'h0, o_home_pos - 32'hEA20 < 32'h80 || o_home_pos - 32'h9C00 < 32'h80});
    lfsr = nxt(lfsr);
    run(M_IDX_POS, {18'h0, lfsr[13:0]});
    chk_run(M_IDX_POS);
    run(M_IDX_NEG, pos);
    chk_run(M_IDX_NEG);
    // Negative limit forced in mid run
    start(8'h0A, 32'h0000_4E20);
    repeat (1000) @(posedge i_clk);
    frc <= '{lim_pos: 1'b0, lim_neg: 1'b1, home: 1'b0, index: 1'b0};
    for (int i = 0; i < 8 && o_error !== 1'b1; i++) @(negedge i_clk);
    chk("limit error", 32'h1, {31'h0, o_error});
    chk("limit vel", 32'h0, o_vel);
    chk("limit busy", 32'h0, {31'h0, o_busy});
    @(posedge i_clk);
    frc <= '0;
    repeat (200) @(posedge i_clk);
    rdc(OFS_STATUS, 32'h2400);
    run(M_HERE_A, 32'h0);
    chk("error cleared", 32'h0, {31'h0, o_error});
    start(M_IDX_NEG, 32'h0000_C350);
    for (int i = 0; i < 10 && o_error !== 1'b1; i++) @(negedge i_clk);
    chk("home error", 32'h1, {31'h0, o_error});
    chk("ramp steps", 32'h0, ramp_bad);
    tally_and_finish();
  end
endmodule
